/* include/crp_pkg.sv */
/*
 * crp_pkg: register indices, field positions, reset values, sequencer
 * states and timing counts for the output/reset/power-down controller.
 * Assumes a 20 MHz system clock and an APB master with 32-bit data.
 */
// Overview of operation
// - bit 0 of each output register puts that differential driver in safe off
// - bits 2:1 of each output register select the differential swing
// - each output has its own polarity bit, noninverting or inverting
// - distribution power-down shuts all drivers and removes distribution bias
// - safe off comes from driver bit, single-ended mode, channel or distribution power-down, or sleep
// - entering single-ended mode turns both A and B on, then each switchable
// - bits 6:5 enable single-ended drivers; disabled ones are tristated
// - power-on pulse reloads from memory if select pin high, else defaults
// - after power-on, align outputs and start toggling about 70 ms later
// - low reset pin resets, reloads per select pin, aligns outputs
// - pin reset: toggle after ~2 us (select low) or ~20 ms (high)
// - bits 2 and 5 of register zero request soft reset and reload
// - soft reset clears bits 2 and 5, keeps the rest of register zero
// - soft reset holds outputs static until one more serial clock arrives
// - memory reload bit works only with select low, self-clears, ~20 ms wait
// - sleep pin low powers down; registers, even new writes, survive
// - in sleep: PLL, dividers off, single-ended tristated, serial port alive
// - two-bit PLL power-down field picks asynchronous or synchronous mode
// - async powers down on update; sync waits for next charge pump event
// - channel bit 2 powers down its divider and all its drivers
// - written values, except register zero and the reload bit, take effect only on the update-all-registers write
// - alignment holds non-excluded channels static, then releases together
package crp_pkg;

  // ---------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------
  localparam int APB_AW      = 14;
  localparam int NUM_OUT     = 12;
  localparam int NUM_CH      = 4;
  localparam int OUTS_PER_CH = 3;
  localparam int TMR_W       = 21;

  // ---------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [11:0] IDX_SPCFG  = 12'h000;
  localparam logic [11:0] IDX_PLL    = 12'h010;
  localparam logic [11:0] IDX_OUT0   = 12'h0f0;
  localparam logic [11:0] IDX_CH0    = 12'h192;
  localparam logic [11:0] CH_STRIDE  = 12'h003;
  localparam logic [11:0] IDX_DIST   = 12'h230;
  localparam logic [11:0] IDX_UPD    = 12'h232;
  localparam logic [11:0] IDX_STAT   = 12'h234;
  localparam logic [11:0] IDX_NVM    = 12'hb02;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int SP_SRST_LO   = 2;
  localparam int SP_SRST_HI   = 5;
  localparam int OUT_PD_BIT   = 0;
  localparam int OUT_SW_LSB   = 1;
  localparam int OUT_SE_BIT   = 3;
  localparam int OUT_INV_BIT  = 4;
  localparam int OUT_SEA_BIT  = 5;
  localparam int OUT_SEB_BIT  = 6;
  localparam int CH_PD_BIT    = 2;
  localparam int CH_EXCL_BIT  = 6;
  localparam int DIST_SYNC_BIT = 0;
  localparam int DIST_PD_BIT  = 1;
  localparam int UPD_BIT      = 0;
  localparam int NVM_LD_BIT   = 1;

  // ---------------------------------------------------------------------
  // reset values and PLL modes
  // ---------------------------------------------------------------------
  localparam logic [7:0] SP_RST   = 8'h00;
  localparam logic [7:0] PLL_RST  = 8'h00;
  localparam logic [7:0] OUT_RST  = 8'h02;
  localparam logic [7:0] CH_RST   = 8'h00;
  localparam logic [7:0] DIST_RST = 8'h00;
  localparam logic [1:0] PLL_PD_ASYNC = 2'h1;
  localparam logic [1:0] PLL_PD_SYNC  = 2'h3;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned POR_WAIT_MS   = 70;
  localparam int unsigned PIN_NVM_MS    = 20;
  localparam int unsigned NVM_WAIT_MS   = 20;
  localparam int unsigned PIN_DEF_NS    = 2000;
  localparam int unsigned POR_CYC       = POR_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned PIN_NVM_CYC   = PIN_NVM_MS * (CLK_HZ / 1000);
  localparam int unsigned NVM_CYC       = NVM_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned PIN_DEF_CYC   =
    (PIN_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset sequencer
  typedef enum logic [2:0] {
    SEQ_INIT = 3'h0,
    SEQ_RUN  = 3'h1,
    SEQ_HOLD = 3'h2,
    SEQ_TMR  = 3'h3,
    SEQ_SCLK = 3'h4
  } crp_seq_type;

endpackage : crp_pkg

/* core/crp_ctrl.sv */
/*
 * crp_ctrl: output driver configuration, reset sources and power-down
 * control behind an APB register port. All inputs are synchronous to
 * clk_sys; nonvolatile contents are written back by an outside loader
 * over APB while nvm_load_r is high.
 */
`timescale 1ns/1ps
module crp_ctrl import crp_pkg::*; #(
  parameter int unsigned POR_WAIT_CYC = POR_CYC,
  parameter int unsigned PIN_NVM_CYC_P = PIN_NVM_CYC,
  parameter int unsigned NVM_WAIT_CYC = NVM_CYC
) (
  // clock, reset, enable
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // reset and power pins, internal events
  input  wire logic                  por_pulse,
  input  wire logic                  reset_pin_n,
  input  wire logic                  mem_sel,
  input  wire logic                  chip_sleep_n,
  input  wire logic                  sclk_tick,
  input  wire logic                  cp_event,
  // driver and core controls
  output logic [NUM_OUT-1:0]         drv_pd,
  output logic [2*NUM_OUT-1:0]       drv_swing,
  output logic [NUM_OUT-1:0]         drv_invert,
  output logic [NUM_OUT-1:0]         se_a_en,
  output logic [NUM_OUT-1:0]         se_b_en,
  output logic                       dist_off,
  output logic [NUM_CH-1:0]          div_off,
  output logic [NUM_CH-1:0]          align_hold,
  output logic                       pll_off,
  output logic                       out_static,
  output logic                       nvm_load_r
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    crp_seq_type                    seq;
    logic [TMR_W-1:0]               tmr;
    logic                           nvm_ld;
    logic [7:0]                     sp;
    logic [7:0]                     pll_sh;
    logic [7:0]                     pll_act;
    logic [NUM_OUT-1:0][7:0]        out_sh;
    logic [NUM_OUT-1:0][7:0]        out_act;
    logic [NUM_CH-1:0][7:0]         ch_sh;
    logic [NUM_CH-1:0][7:0]         ch_act;
    logic [7:0]                     dist_sh;
    logic [7:0]                     dist_act;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    logic [NUM_OUT-1:0]             drv_pd;
    logic [2*NUM_OUT-1:0]           swing;
    logic [NUM_OUT-1:0]             inv;
    logic [NUM_OUT-1:0]             se_a;
    logic [NUM_OUT-1:0]             se_b;
    logic                           dist_off;
    logic [NUM_CH-1:0]              div_off;
    logic [NUM_CH-1:0]              align;
    logic                           pll_off;
    logic                           stat;
  } crp_state_type;

  crp_state_type s_r;
  crp_state_type s_nxt;

  // ---------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------
  // output register hit: 0x0f0..0x0fb
  function automatic logic is_out(input logic [11:0] idx);
    is_out = (idx >= IDX_OUT0) && (idx < IDX_OUT0 + 12'(NUM_OUT));
  endfunction : is_out

  function automatic logic [3:0] out_num(input logic [11:0] idx);
    out_num = 4'(idx - IDX_OUT0);
  endfunction : out_num

  // channel register hit: 0x192, 0x195, 0x198, 0x19b
  function automatic logic is_ch(input logic [11:0] idx);
    logic [11:0] d;
    d = idx - IDX_CH0;
    is_ch = (idx >= IDX_CH0) && (d < CH_STRIDE * 12'(NUM_CH))
            && (d % CH_STRIDE == 12'h000);
  endfunction : is_ch

  function automatic logic [1:0] ch_num(input logic [11:0] idx);
    ch_num = 2'((idx - IDX_CH0) / CH_STRIDE);
  endfunction : ch_num

  function automatic logic mapped(input logic [11:0] idx);
    mapped = is_out(idx) || is_ch(idx) || idx == IDX_SPCFG
             || idx == IDX_PLL || idx == IDX_DIST || idx == IDX_UPD
             || idx == IDX_STAT || idx == IDX_NVM;
  endfunction : mapped

  // defaults into shadow and live copies; register zero kept on request
  function automatic crp_state_type load_dflt(input crp_state_type s,
                                              input logic keep_sp);
    crp_state_type t;
    t = s;
    if (!keep_sp) begin
      t.sp = SP_RST;
    end
    t.pll_sh   = PLL_RST;
    t.pll_act  = PLL_RST;
    t.dist_sh  = DIST_RST;
    t.dist_act = DIST_RST;
    for (int i = 0; i < NUM_OUT; i++) begin
      t.out_sh[i]  = OUT_RST;
      t.out_act[i] = OUT_RST;
    end
    for (int k = 0; k < NUM_CH; k++) begin
      t.ch_sh[k]  = CH_RST;
      t.ch_act[k] = CH_RST;
    end
    load_dflt = t;
  endfunction : load_dflt

  // ---------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------
  logic [11:0] idx;
  logic        acc;
  logic        wr_go;
  logic        sleep;
  logic [7:0]  rd_val;

  assign idx   = paddr[APB_AW-1:2];
  assign acc   = psel & penable;
  // the write lands on the edge where the master sees pready
  assign wr_go = acc & s_r.pready & pwrite & mapped(idx);
  assign sleep = ~chip_sleep_n;

  // read mux shows shadow copies, so software sees what it wrote
  always_comb begin
    rd_val = 8'h00;
    if (is_out(idx)) begin
      rd_val = s_r.out_sh[out_num(idx)];
    end else if (is_ch(idx)) begin
      rd_val = s_r.ch_sh[ch_num(idx)];
    end else begin
      case (idx)
        IDX_SPCFG: rd_val = s_r.sp;
        IDX_PLL:   rd_val = s_r.pll_sh;
        IDX_DIST:  rd_val = s_r.dist_sh;
        IDX_NVM:   rd_val = {6'h00, s_r.nvm_ld, 1'b0};
        IDX_STAT:  rd_val = {2'h0, s_r.seq, s_r.pll_off, sleep, s_r.stat};
        default:   rd_val = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [7:0] w;
    logic [7:0] o;
    logic       soft_go;
    logic       nvm_go;
    logic       chpd;
    logic       kill;
    logic [3:0] oi;
    w       = pwdata[7:0];
    o       = 8'h00;
    soft_go = 1'b0;
    nvm_go  = 1'b0;
    chpd    = 1'b0;
    kill    = 1'b0;
    oi      = 4'h0;
    s_nxt   = s_r;
    if (ce) begin
      // apb: one wait state, then answer for exactly one cycle
      if (acc && !s_r.pready) begin
        s_nxt.pready  = 1'b1;
        s_nxt.prdata  = {24'h000000, rd_val};
        s_nxt.pslverr = ~mapped(idx);
      end else begin
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
      end

      // register writes land in shadows; sleep does not block them
      if (wr_go) begin
        if (is_out(idx)) begin
          oi = out_num(idx);
          o  = w;
          // entering single-ended mode switches on both halves
          if (w[OUT_SE_BIT] && !s_r.out_sh[oi][OUT_SE_BIT]) begin
            o[OUT_SEA_BIT] = 1'b1;
            o[OUT_SEB_BIT] = 1'b1;
          end
          s_nxt.out_sh[oi] = o;
        end else if (is_ch(idx)) begin
          s_nxt.ch_sh[ch_num(idx)] = w;
        end else begin
          case (idx)
            IDX_SPCFG: begin
              s_nxt.sp = w;
              soft_go  = w[SP_SRST_LO] & w[SP_SRST_HI];
            end
            IDX_PLL:  s_nxt.pll_sh  = w;
            IDX_DIST: s_nxt.dist_sh = w;
            IDX_UPD: begin
              // shadow to live copy only on the update strobe
              if (w[UPD_BIT]) begin
                s_nxt.pll_act  = s_r.pll_sh;
                s_nxt.out_act  = s_r.out_sh;
                s_nxt.ch_act   = s_r.ch_sh;
                s_nxt.dist_act = s_r.dist_sh;
              end
            end
            IDX_NVM: nvm_go = w[NVM_LD_BIT] & ~mem_sel;
            default: ;
          endcase
        end
      end

      // reset sources, highest priority last so it wins
      case (s_r.seq)
        SEQ_INIT: begin
          s_nxt     = load_dflt(s_nxt, 1'b0);
          s_nxt.seq = SEQ_RUN;
        end
        SEQ_HOLD: begin
          // pin still low keeps everything in reset
          if (reset_pin_n) begin
            s_nxt.seq = SEQ_TMR;
            s_nxt.tmr = mem_sel ? TMR_W'(PIN_NVM_CYC_P - 1)
                                : TMR_W'(PIN_DEF_CYC - 1);
          end
        end
        SEQ_TMR: begin
          if (s_r.tmr == '0) begin
            s_nxt.seq    = SEQ_RUN;
            s_nxt.nvm_ld = 1'b0;
          end else begin
            s_nxt.tmr = s_r.tmr - 1'b1;
          end
        end
        SEQ_SCLK: begin
          // soft reset ends only on a further serial clock
          if (sclk_tick) begin
            s_nxt.sp[SP_SRST_LO] = s_nxt.sp[SP_SRST_LO] & (wr_go && idx == IDX_SPCFG);
            s_nxt.sp[SP_SRST_HI] = s_nxt.sp[SP_SRST_HI] & (wr_go && idx == IDX_SPCFG);
            s_nxt.seq            = SEQ_RUN;
            s_nxt.nvm_ld         = 1'b0;
          end
        end
        SEQ_RUN: ;
        default: s_nxt.seq = SEQ_INIT;
      endcase

      if (nvm_go && s_r.seq == SEQ_RUN) begin
        s_nxt        = load_dflt(s_nxt, 1'b1);
        s_nxt.nvm_ld = 1'b1;
        s_nxt.seq    = SEQ_TMR;
        s_nxt.tmr    = TMR_W'(NVM_WAIT_CYC - 1);
      end
      if (soft_go) begin
        // other bits of register zero survive the reload
        s_nxt        = load_dflt(s_nxt, 1'b1);
        s_nxt.nvm_ld = mem_sel;
        s_nxt.seq    = SEQ_SCLK;
      end
      if (!reset_pin_n) begin
        s_nxt        = load_dflt(s_nxt, 1'b0);
        s_nxt.nvm_ld = mem_sel;
        s_nxt.seq    = SEQ_HOLD;
      end
      if (por_pulse) begin
        s_nxt        = load_dflt(s_nxt, 1'b0);
        s_nxt.nvm_ld = mem_sel;
        s_nxt.seq    = SEQ_TMR;
        s_nxt.tmr    = TMR_W'(POR_WAIT_CYC - 1);
      end

      // any running reset sequence freezes the outputs
      s_nxt.stat = (s_r.seq != SEQ_RUN);

      // output drivers from live copies
      s_nxt.dist_off = s_r.dist_act[DIST_PD_BIT];
      for (int i = 0; i < NUM_OUT; i++) begin
        chpd = s_r.ch_act[i / OUTS_PER_CH][CH_PD_BIT];
        kill = chpd | sleep | s_r.dist_act[DIST_PD_BIT];
        // safe off from own bit, single-ended mode, channel, sleep or total shutdown
        s_nxt.drv_pd[i] = s_r.out_act[i][OUT_PD_BIT]
                          | kill
                          | s_r.out_act[i][OUT_SE_BIT];
        s_nxt.swing[2*i +: 2] =
          s_r.out_act[i][OUT_SW_LSB +: 2];
        s_nxt.inv[i] = s_r.out_act[i][OUT_INV_BIT];
        // a disabled single-ended half is tristated by the pad
        s_nxt.se_a[i] = s_r.out_act[i][OUT_SE_BIT]
                        & s_r.out_act[i][OUT_SEA_BIT] & ~kill;
        s_nxt.se_b[i] = s_r.out_act[i][OUT_SE_BIT]
                        & s_r.out_act[i][OUT_SEB_BIT] & ~kill;
      end

      // dividers and alignment hold per channel
      for (int k = 0; k < NUM_CH; k++) begin
        s_nxt.div_off[k] = s_r.ch_act[k][CH_PD_BIT]
                           | sleep;
        // excluded channels keep running through an alignment
        s_nxt.align[k] = ~s_r.ch_act[k][CH_EXCL_BIT]
                         & (s_r.seq != SEQ_RUN
                            | s_r.dist_act[DIST_SYNC_BIT]
                            | s_r.dist_act[DIST_PD_BIT]
                            | sleep);
      end

      // pll power-down: sync mode waits for the pump so no frequency jump
      if (sleep) begin
        s_nxt.pll_off = 1'b1;
      end else begin
        case (s_r.pll_act[1:0])
          PLL_PD_ASYNC: s_nxt.pll_off = 1'b1;
          PLL_PD_SYNC:  s_nxt.pll_off = s_r.pll_off | cp_event;
          default:      s_nxt.pll_off = 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  // reset to zero; the INIT state loads real defaults one cycle later
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign prdata     = s_r.prdata;
  assign pready     = s_r.pready;
  assign pslverr    = s_r.pslverr;
  assign drv_pd     = s_r.drv_pd;
  assign drv_swing  = s_r.swing;
  assign drv_invert = s_r.inv;
  assign se_a_en    = s_r.se_a;
  assign se_b_en    = s_r.se_b;
  assign dist_off   = s_r.dist_off;
  assign div_off    = s_r.div_off;
  assign align_hold = s_r.align;
  assign pll_off    = s_r.pll_off;
  assign out_static = s_r.stat;
  assign nvm_load_r = s_r.nvm_ld;

endmodule : crp_ctrl

/* tb/crp_ctrl_monitor.sv */
/* crp_ctrl_monitor: port-level assertions for crp_ctrl.
   assumes ce is held high and that it is bound into crp_ctrl. */
`timescale 1ns/1ps
module crp_ctrl_monitor import crp_pkg::*; (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  // bus and pins
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [APB_AW-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               por_pulse,
  input wire logic               reset_pin_n,
  input wire logic               chip_sleep_n,
  // controls watched
  input wire logic [NUM_OUT-1:0] drv_pd,
  input wire logic [NUM_OUT-1:0] drv_invert,
  input wire logic [NUM_OUT-1:0] se_a_en,
  input wire logic [NUM_OUT-1:0] se_b_en,
  input wire logic [NUM_CH-1:0]  div_off,
  input wire logic               pll_off,
  input wire logic               out_static
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic              upd_w;
  logic [NUM_CH-1:0] grp_pd;
  // completed write of the update bit
  assign upd_w = psel && penable && pready && pwrite && (paddr[13:2] == IDX_UPD) && pwdata[UPD_BIT];
  // all three drivers of a channel off
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      grp_pd[k] = &drv_pd[OUTS_PER_CH*k +: OUTS_PER_CH];
    end
  end
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_pready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_sleep_all_off: assert property (!chip_sleep_n [*4] |-> pll_off && (&div_off) && (&drv_pd)
    && !(|se_a_en) && !(|se_b_en))
    else $error("sleep did not power down the outputs");
  a_pin_static: assert property (!reset_pin_n [*3] |-> out_static)
    else $error("reset pin low without static outputs");
  a_por_static: assert property (por_pulse |-> ##[1:3] out_static)
    else $error("power-on pulse did not hold outputs static");
  a_channel_drivers: assert property ((div_off & ~grp_pd) == '0)
    else $error("channel off with a driver still on");
  a_update_gate: assert property ($changed(drv_invert) |-> $past(upd_w, 2) || $past(out_static)
    || out_static)
    else $error("polarity changed without an update");
endmodule : crp_ctrl_monitor

/* tb/crp_sclk_src.sv */
/* crp_sclk_src: host-side serial clock source, one tick every four cycles.
   assumes the bench raises run only when serial clocking is wanted. */
`timescale 1ns/1ps
module crp_sclk_src (
  // clock and control
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic run,
  // serial clock cycles
  output logic      sclk_tick
);
  logic [1:0] div_r;
  // clock stands still while idle, so a soft reset waits for the host
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      div_r     <= 2'h0;
      sclk_tick <= 1'b0;
    end else begin
      div_r     <= div_r + 2'h1;
      sclk_tick <= (div_r == 2'h3);
    end
  end
endmodule : crp_sclk_src

/* tb/crp_ctrl_tb.sv */
/* crp_ctrl_tb: register-level tests of crp_ctrl.
   assumes shortened wait parameters and a 50 ns clock. */
`timescale 1ns/1ps
module crp_ctrl_tb import crp_pkg::*;;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err, sclk_tick, sclk_run;
  logic por_pulse, reset_pin_n, mem_sel, chip_sleep_n, cp_event, dist_off, pll_off;
  logic out_static, nvm_load_r;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [NUM_OUT-1:0] drv_pd, drv_invert, se_a_en, se_b_en;
  logic [2*NUM_OUT-1:0] drv_swing;
  logic [NUM_CH-1:0] div_off, align_hold;
  int bad_count, n_tests;
  crp_ctrl #(.POR_WAIT_CYC(20), .PIN_NVM_CYC_P(10), .NVM_WAIT_CYC(10)) i_dut (.clk_sys,
    .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .por_pulse, .reset_pin_n, .mem_sel, .chip_sleep_n, .sclk_tick, .cp_event,
    .drv_pd, .drv_swing, .drv_invert, .se_a_en, .se_b_en, .dist_off, .div_off,
    .align_hold, .pll_off, .out_static, .nvm_load_r);
  crp_sclk_src i_sclk (.clk_sys, .sys_rst, .run(sclk_run), .sclk_tick);
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look
  // one apb transfer; request held until pready is seen
  task xfer(input logic [11:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task upd;
    xfer(IDX_UPD, 1'b1, 8'h01);
  endtask : upd
  task wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    wrap_up;
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, por_pulse, cp_event, sclk_run, mem_sel} = '0;
    paddr = '0; pwdata = '0; reset_pin_n = 1'b1; chip_sleep_n = 1'b1; sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    look(3);
    xfer(IDX_OUT0, 1'b0, 8'h00); chk("out0 reset", q, 32'h02);
    xfer(12'h3ff, 1'b0, 8'h00); chk("unmapped", 32'(err), 32'h1);
    xfer(IDX_OUT0, 1'b1, 8'h15); look(3); chk("inv early", 32'(drv_invert[0]), 0);
    upd; look(3); chk("pd0", 32'(drv_pd[0]), 1);
    chk("swing0", 32'(drv_swing[1:0]), 2);
    chk("inv0", 32'(drv_invert[0]), 1);
    // single-ended mode then B switched off alone
    xfer(IDX_OUT0 + 1, 1'b1, 8'h08); upd; look(3);
    chk("se on", 32'({se_b_en[1], se_a_en[1]}), 3);
    xfer(IDX_OUT0 + 1, 1'b1, 8'h28); upd; look(3);
    chk("se a only", 32'({se_b_en[1], se_a_en[1]}), 1);
    // channel 1, distribution and async pll power-down together
    xfer(IDX_CH0 + CH_STRIDE, 1'b1, 8'h04); xfer(IDX_DIST, 1'b1, 8'h02);
    xfer(IDX_PLL, 1'b1, 8'h01); upd; look(3);
    chk("div off", 32'(div_off), 32'h2);
    chk("ch1 drv", 32'(drv_pd[5:3]), 32'h7);
    chk("dist", 32'(dist_off), 1);
    chk("pll async", 32'(pll_off), 1);
    xfer(IDX_PLL, 1'b1, 8'h00); upd; look(3); chk("pll on", 32'(pll_off), 0);
    xfer(IDX_PLL, 1'b1, 8'h03); upd; look(5); chk("pll wait cp", 32'(pll_off), 0);
    @(posedge clk_sys) cp_event <= 1'b1;
    @(posedge clk_sys) cp_event <= 1'b0;
    look(3); chk("pll sync", 32'(pll_off), 1);
    // sleep with a write landing meanwhile
    @(posedge clk_sys) chip_sleep_n <= 1'b0;
    xfer(IDX_OUT0 + 2, 1'b1, 8'h10); xfer(IDX_DIST, 1'b1, 8'h00); upd; look(3);
    chk("sleep pd", 32'(drv_pd), 32'hfff);
    chk("sleep se", 32'(se_a_en | se_b_en), 0);
    @(posedge clk_sys) chip_sleep_n <= 1'b1;
    look(4); chk("wake inv", 32'(drv_invert[2]), 1);
    chk("wake pd", 32'(drv_pd[2]), 0);
    chk("wake ch1", 32'(drv_pd[5:3]), 32'h7);
    // channel 0 excluded, soft sync holds the others
    xfer(IDX_CH0, 1'b1, 8'h40); xfer(IDX_DIST, 1'b1, 8'h01); upd; look(3);
    chk("align excl", 32'(align_hold), 32'he);
    // soft reset waits for a serial clock cycle
    xfer(IDX_SPCFG, 1'b1, 8'ha4); look(10); chk("soft hold", 32'(out_static), 1);
    @(posedge clk_sys) sclk_run <= 1'b1;
    look(10); chk("soft done", 32'(out_static), 0);
    xfer(IDX_SPCFG, 1'b0, 8'h00); chk("spcfg kept", q, 32'h80);
    xfer(IDX_OUT0, 1'b0, 8'h00); chk("out0 dflt", q, 32'h02);
    // memory reload works only with select low
    xfer(IDX_NVM, 1'b1, 8'h02); look(2); chk("nvm load", 32'(nvm_load_r), 1);
    look(15); chk("nvm done", 32'(out_static), 0);
    @(posedge clk_sys) mem_sel <= 1'b1;
    xfer(IDX_NVM, 1'b1, 8'h02); look(3); chk("nvm ignored", 32'(nvm_load_r), 0);
    // pin reset, memory then defaults
    @(posedge clk_sys) reset_pin_n <= 1'b0;
    look(3); chk("pin hold", 32'(out_static), 1);
    @(posedge clk_sys) reset_pin_n <= 1'b1;
    look(3); chk("pin nvm", 32'(nvm_load_r), 1);
    look(15); chk("pin nvm end", 32'(out_static), 0);
    @(posedge clk_sys) begin
      reset_pin_n <= 1'b0;
      mem_sel     <= 1'b0;
    end
    look(3);
    @(posedge clk_sys) reset_pin_n <= 1'b1;
    look(30); chk("pin dflt wait", 32'(out_static), 1);
    look(20); chk("pin dflt end", 32'(out_static), 0);
    // power-on pulse
    @(posedge clk_sys) por_pulse <= 1'b1;
    @(posedge clk_sys) por_pulse <= 1'b0;
    look(10); chk("por hold", 32'(out_static), 1);
    chk("por dflt", 32'(nvm_load_r), 0);
    chk("por align", 32'(align_hold), 32'hf);
    look(20); chk("por end", 32'(out_static), 0);
    wrap_up;
  end
endmodule : crp_ctrl_tb
bind crp_ctrl crp_ctrl_monitor u_mon (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .por_pulse, .reset_pin_n, .chip_sleep_n, .drv_pd,
  .drv_invert, .se_a_en, .se_b_en, .div_off, .pll_off, .out_static);
